// >>> rtl/fpec_top.sv
/*
 * Flash program/erase control: mode control, error status, erase-block select
 * and access-enable registers behind an Avalon-MM slave with waitrequest.
 * Assumes the flash array reports faults on the same clock as ref_clk.
 */
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "fpec_map.svh"

module fpec_top
    import fpec_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             flashFault,
    output fpec_flash_ctrl_t      flashCtrl
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    fpec_state_t state_q;
    fpec_state_t state_d;

    logic       request;
    logic       accept;
    logic       wrAccept;
    logic       rdAccept;
    logic       hitMode;
    logic       hitStatus;
    logic       hitBlk;
    logic       hitAccess;
    logic       lowLane;
    logic [7:0] rdByte;
    logic       newWren;
    logic       newEset;
    logic       newPset;
    logic       opActive;
    logic [6:0] blkWr;
    logic       blkMulti;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // One wait state: the request is seen in IDLE and answered in ACK, so the
    // read data are already in a flop when waitrequest drops.
    assign request   = avs_read | avs_write;
    assign accept    = request & (state_q.busSt == FPEC_BUS_ACK);
    assign wrAccept  = accept & avs_write;
    assign rdAccept  = accept & avs_read;
    assign lowLane   = avs_byteenable[0];

    // The control registers vanish while access is disabled; the access
    // register itself must stay reachable or it could never be set.
    assign hitAccess = (avs_address == `FPEC_OFS_ACCESS);
    assign hitMode   = (avs_address == `FPEC_OFS_MODE_CTL) & state_q.accessEn;   // RQ17
    assign hitStatus = (avs_address == `FPEC_OFS_ERR_STATUS) & state_q.accessEn; // RQ17
    assign hitBlk    = (avs_address == `FPEC_OFS_ERASE_BLK) & state_q.accessEn;  // RQ17

    assign avs_waitrequest = request & (state_q.busSt != FPEC_BUS_ACK);
    assign avs_readdata    = state_q.rdata;

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always_comb begin
        rdByte = 8'h00;
        if (hitMode) begin
            rdByte = {1'b0, state_q.modeCtl[6:0]};              // RQ14
        end else if (hitStatus) begin
            rdByte = {state_q.errFlag, 7'h00};                  // RQ15
        end else if (hitBlk) begin
            rdByte = {1'b0, state_q.eraseBlk[6:0]};
        end else if (hitAccess) begin
            rdByte = {state_q.accessEn, 7'h00};
        end
    end

    // ------------------------------------------------------------------------
    // Write helpers
    // ------------------------------------------------------------------------
    assign newWren  = avs_writedata[`FPEC_MC_WREN];
    assign newEset  = avs_writedata[`FPEC_MC_ESET] & newWren;
    assign newPset  = avs_writedata[`FPEC_MC_PSET] & newWren;
    assign opActive = state_q.modeCtl[`FPEC_MC_E] | state_q.modeCtl[`FPEC_MC_P];
    assign blkWr    = avs_writedata[6:0];
    assign blkMulti = ($countones(blkWr) > 1);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        case (state_q.busSt)
            FPEC_BUS_IDLE: begin
                if (request) begin
                    state_d.busSt = FPEC_BUS_ACK;
                    state_d.rdata = {24'h00_0000, rdByte};
                end
            end
            FPEC_BUS_ACK: begin
                state_d.busSt = FPEC_BUS_IDLE;
            end
            default: begin
                state_d.busSt = FPEC_BUS_IDLE;
            end
        endcase

        if (wrAccept & lowLane & hitAccess) begin
            state_d.accessEn = avs_writedata[`FPEC_ACC_EN];
        end

        // Writes to the status register are dropped; software must not issue
        // them, and they have no effect when it does.
        if (wrAccept & lowLane & hitMode) begin
            state_d.modeCtl = 8'h00;                                                // RQ2
            state_d.modeCtl[`FPEC_MC_WREN] = newWren;                               // RQ1
            state_d.modeCtl[`FPEC_MC_ESET] = newEset;                               // RQ3
            state_d.modeCtl[`FPEC_MC_PSET] = newPset;                               // RQ5
            state_d.modeCtl[`FPEC_MC_EVFY] = avs_writedata[`FPEC_MC_EVFY] & newWren; // RQ7
            state_d.modeCtl[`FPEC_MC_PVFY] = avs_writedata[`FPEC_MC_PVFY] & newWren; // RQ8
            // Erase and program only take when their setup bit already holds,
            // so a single write cannot skip the setup step.
            state_d.modeCtl[`FPEC_MC_E] = avs_writedata[`FPEC_MC_E] & newEset
                                          & state_q.modeCtl[`FPEC_MC_ESET];         // RQ9
            state_d.modeCtl[`FPEC_MC_P] = avs_writedata[`FPEC_MC_P] & newPset
                                          & state_q.modeCtl[`FPEC_MC_PSET];         // RQ10
        end

        if (wrAccept & lowLane & hitBlk & state_q.modeCtl[`FPEC_MC_WREN]) begin  // RQ2
            // More than one block selected clears the whole selection.
            state_d.eraseBlk = blkMulti ? `FPEC_RST_ERASE_BLK : {1'b0, blkWr};
        end

        if (!state_d.modeCtl[`FPEC_MC_WREN]) begin
            state_d.eraseBlk = `FPEC_RST_ERASE_BLK;                                 // RQ16
        end

        if (flashFault & opActive) begin
            state_d.errFlag = 1'b1;                                                 // RQ11
        end

        if (state_d.errFlag) begin
            state_d.modeCtl[`FPEC_MC_E] = 1'b0;                                     // RQ12
            state_d.modeCtl[`FPEC_MC_P] = 1'b0;                                     // RQ12
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q.busSt    <= FPEC_BUS_IDLE;
            state_q.modeCtl  <= `FPEC_RST_MODE_CTL;
            state_q.eraseBlk <= `FPEC_RST_ERASE_BLK;
            state_q.errFlag  <= `FPEC_RST_ERR;
            state_q.accessEn <= `FPEC_RST_ACCESS;
            state_q.rdata    <= `FPEC_RST_RDATA;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Flash array controls
    // ------------------------------------------------------------------------
    always_comb begin
        flashCtrl.eraseSetup    = state_q.modeCtl[`FPEC_MC_ESET];
        flashCtrl.programSetup  = state_q.modeCtl[`FPEC_MC_PSET];
        flashCtrl.eraseVerify   = state_q.modeCtl[`FPEC_MC_EVFY];
        flashCtrl.programVerify = state_q.modeCtl[`FPEC_MC_PVFY];
        flashCtrl.eraseMode     = state_q.modeCtl[`FPEC_MC_E];
        flashCtrl.programMode   = state_q.modeCtl[`FPEC_MC_P];
        flashCtrl.errorProtect  = state_q.errFlag;
        flashCtrl.eraseBlocks   = state_q.eraseBlk[6:0];
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_modeWrite;
        wrAccept && lowLane && hitMode;
    endsequence

    sequence s_modeRead;
        rdAccept && (avs_address == `FPEC_OFS_MODE_CTL) && state_q.accessEn;
    endsequence

    property p_wr_en_gate;
        s_modeWrite ##0 !avs_writedata[`FPEC_MC_WREN] |=> (state_q.modeCtl == 8'h00);
    endproperty
    a_wr_en_gate: assert property (p_wr_en_gate)                               // RQ2
        else $error("Mode bits set while write enable was written 0.");

    property p_wr_en_take;
        s_modeWrite ##0 avs_writedata[`FPEC_MC_WREN] |=> state_q.modeCtl[`FPEC_MC_WREN];
    endproperty
    a_wr_en_take: assert property (p_wr_en_take)                               // RQ1
        else $error("Write enable did not take.");

    property p_erase_setup;
        s_modeWrite ##0 (avs_writedata[6:5] == 2'b11) |=> flashCtrl.eraseSetup;
    endproperty
    a_erase_setup: assert property (p_erase_setup)                             // RQ3
        else $error("Erase setup state not entered.");

    property p_program_setup;
        s_modeWrite ##0 (avs_writedata[`FPEC_MC_PSET] == 1'b0) |=> !flashCtrl.programSetup;
    endproperty
    a_program_setup: assert property (p_program_setup)                         // RQ5
        else $error("Program setup state not left.");

    property p_verify;
        s_modeWrite ##0 avs_writedata[`FPEC_MC_WREN] |=>
            (flashCtrl.eraseVerify == $past(avs_writedata[`FPEC_MC_EVFY]))
            && (flashCtrl.programVerify == $past(avs_writedata[`FPEC_MC_PVFY]));
    endproperty
    a_verify: assert property (p_verify)                                       // RQ7 RQ8
        else $error("Verify mode does not follow its bit.");

    property p_erase_mode;
        flashCtrl.eraseMode |-> flashCtrl.eraseSetup
            && state_q.modeCtl[`FPEC_MC_WREN] && !state_q.errFlag;
    endproperty
    a_erase_mode: assert property (p_erase_mode)                               // RQ9
        else $error("Erase mode without write enable and erase setup.");

    property p_program_mode;
        $rose(flashCtrl.programMode) |-> $past(flashCtrl.programSetup)
            && state_q.modeCtl[`FPEC_MC_WREN];
    endproperty
    a_program_mode: assert property (p_program_mode)                           // RQ10
        else $error("Program mode entered without program setup held.");

    property p_err_set;
        flashFault && opActive |=> state_q.errFlag [*3];
    endproperty
    a_err_set: assert property (p_err_set)                                     // RQ11
        else $error("Error flag not set and held after a fault.");

    property p_err_protect;
        state_q.errFlag |-> !flashCtrl.eraseMode && !flashCtrl.programMode
            && flashCtrl.errorProtect;
    endproperty
    a_err_protect: assert property (p_err_protect)                             // RQ12
        else $error("Program or erase active under error protection.");

    property p_mode_read;
        s_modeRead |-> (avs_readdata[31:7] == 25'h000_0000);
    endproperty
    a_mode_read: assert property (p_mode_read)                                 // RQ14
        else $error("Mode control reads nonzero above bit 6.");

    property p_status_read;
        rdAccept && (avs_address == `FPEC_OFS_ERR_STATUS)
            |-> (avs_readdata[6:0] == 7'h00) && (avs_readdata[31:8] == 24'h00_0000);
    endproperty
    a_status_read: assert property (p_status_read)                             // RQ15
        else $error("Status reads nonzero in reserved bits.");

    property p_blk_clear;
        !state_q.modeCtl[`FPEC_MC_WREN] |-> (state_q.eraseBlk == 8'h00);
    endproperty
    a_blk_clear: assert property (p_blk_clear)                                 // RQ16
        else $error("Erase block selection held with write enable 0.");

    property p_access_block;
        wrAccept && !state_q.accessEn && !hitAccess |=> $stable(state_q.modeCtl)
            && $stable(state_q.eraseBlk);
    endproperty
    a_access_block: assert property (p_access_block)                           // RQ17
        else $error("Control register written while access disabled.");

    property p_bus_answer;
        request && !$past(request) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus answer not given after one wait cycle.");

    property p_blk_gate;
        wrAccept && lowLane && hitBlk && !state_q.modeCtl[`FPEC_MC_WREN]
            |=> (state_q.eraseBlk == 8'h00);
    endproperty
    a_blk_gate: assert property (p_blk_gate)                                   // RQ2
        else $error("Erase block selection set with write enable 0.");

    property p_erase_setup_leave;
        s_modeWrite ##0 !avs_writedata[`FPEC_MC_ESET] |=> !flashCtrl.eraseSetup;
    endproperty
    a_erase_setup_leave: assert property (p_erase_setup_leave)                 // RQ3
        else $error("Erase setup state not left.");

    property p_program_setup_enter;
        s_modeWrite ##0 avs_writedata[`FPEC_MC_WREN] && avs_writedata[`FPEC_MC_PSET]
            |=> flashCtrl.programSetup;
    endproperty
    a_program_setup_enter: assert property (p_program_setup_enter)             // RQ5
        else $error("Program setup state not entered.");

    property p_erase_entry;
        $rose(flashCtrl.eraseMode) |-> $past(flashCtrl.eraseSetup) && flashCtrl.eraseSetup;
    endproperty
    a_erase_entry: assert property (p_erase_entry)                             // RQ9
        else $error("Erase mode entered without erase setup held.");

    property p_erase_cancel;
        s_modeWrite ##0 !avs_writedata[`FPEC_MC_E] |=> !flashCtrl.eraseMode;
    endproperty
    a_erase_cancel: assert property (p_erase_cancel)                           // RQ9
        else $error("Erase mode not cancelled.");

    property p_program_cancel;
        s_modeWrite ##0 !avs_writedata[`FPEC_MC_P] |=> !flashCtrl.programMode;
    endproperty
    a_program_cancel: assert property (p_program_cancel)                       // RQ10
        else $error("Program mode not cancelled.");

    property p_err_sticky;
        state_q.errFlag |=> state_q.errFlag;
    endproperty
    a_err_sticky: assert property (p_err_sticky)                               // RQ11
        else $error("Error flag cleared without reset.");

    property p_fault_idle;
        flashFault && !opActive && !state_q.errFlag |=> !state_q.errFlag;
    endproperty
    a_fault_idle: assert property (p_fault_idle)                               // RQ11
        else $error("Error flag set with no program or erase active.");

    property p_access_read;
        rdAccept && !state_q.accessEn && !hitAccess |-> (avs_readdata == 32'h0000_0000);
    endproperty
    a_access_read: assert property (p_access_read)                             // RQ17
        else $error("Control register read while access disabled.");

endmodule // fpec_top

// >>> inc/fpec_map.svh
/*
 * Register offsets, field positions, reset values and the bus answer timing
 * of the flash program/erase control block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
// Summary of operation
// RQ1: Write-enable bit 6 of mode control set allows program and erase to start.
// RQ2: With write-enable 0, other mode bits and erase-block bits cannot be set.
// RQ3: Erase-setup bit 5 set enters erase-setup state; cleared leaves it.
// RQ4: Software sets erase-setup before it sets the erase bit 1.
// RQ5: Program-setup bit 4 set enters program-setup state; cleared leaves it.
// RQ6: Software sets program-setup before it sets the program bit 0.
// RQ7: Erase-verify bit 3 set enters erase-verify mode; cleared cancels it.
// RQ8: Program-verify bit 2 set enters program-verify mode; cleared cancels it.
// RQ9: Erase mode only when erase bit set with write-enable and erase-setup both 1.
// RQ10: Program mode only when program bit set with write-enable and program-setup 1.
// RQ11: Error flag, status bit 7, sets on a program or erase error; resets to 0.
// RQ12: While the error flag is 1 programming and erasing stay blocked.
// RQ13: Software never writes the read-only error status register.
// RQ14: Mode control bit 7 always reads 0.
// RQ15: Error status bits 6 to 0 always read 0.
// RQ16: With write-enable 0 the erase-block select register stays cleared.
// RQ17: Control registers are reachable only while access-enable bit 7 is 1.
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FPEC_OFS_MODE_CTL     4'h0
`define FPEC_OFS_ERR_STATUS   4'h4
`define FPEC_OFS_ERASE_BLK    4'h8
`define FPEC_OFS_ACCESS       4'hC

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FPEC_MC_WREN          6
`define FPEC_MC_ESET          5
`define FPEC_MC_PSET          4
`define FPEC_MC_EVFY          3
`define FPEC_MC_PVFY          2
`define FPEC_MC_E             1
`define FPEC_MC_P             0
`define FPEC_ST_ERR           7
`define FPEC_ACC_EN           7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FPEC_RST_MODE_CTL     8'h00
`define FPEC_RST_ERASE_BLK    8'h00
`define FPEC_RST_ERR          1'b0
`define FPEC_RST_ACCESS       1'b0
`define FPEC_RST_RDATA        32'h0000_0000

// ----------------------------------------------------------------------------
// Bus timing: cycles from the edge that sees a request to the answer edge
// ----------------------------------------------------------------------------
`define FPEC_WAIT_CYCLES      1

`endif

// >>> inc/fpec_pkg.sv
/*
 * Types of the flash program/erase control block.
 * Assumes fpec_map.svh supplies the numeric constants.
 */
package fpec_pkg;

    // ------------------------------------------------------------------------
    // Bus answer sequencer, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        FPEC_BUS_IDLE = 2'b01,
        FPEC_BUS_ACK  = 2'b10
    } fpec_bus_st_t;

    // ------------------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        fpec_bus_st_t busSt;
        logic [7:0]   modeCtl;
        logic [7:0]   eraseBlk;
        logic         errFlag;
        logic         accessEn;
        logic [31:0]  rdata;
    } fpec_state_t;

    // ------------------------------------------------------------------------
    // Controls presented to the flash array
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       eraseSetup;
        logic       programSetup;
        logic       eraseVerify;
        logic       programVerify;
        logic       eraseMode;
        logic       programMode;
        logic       errorProtect;
        logic [6:0] eraseBlocks;
    } fpec_flash_ctrl_t;

endpackage

// >>> test/fpec_tb.sv
/*
 * Self-checking bench of the flash program/erase control block: directed
 * sequences and xorshift-driven register traffic over Avalon-MM.
 * Assumes the offsets and field positions of fpec_map.svh and one wait cycle.
 */
`timescale 1ns/10ps
`include "fpec_map.svh"

module tb
    import fpec_pkg::*;
;
    logic             ref_clk;
    logic             rstn;
    logic [3:0]       avs_address;
    logic             avs_read;
    logic             avs_write;
    logic [31:0]      avs_writedata;
    logic [3:0]       avs_byteenable;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             flashFault;
    fpec_flash_ctrl_t flashCtrl;
    int               err_total;
    int               checked;
    logic [31:0]      rng;
    logic [7:0]       mMode;
    logic [7:0]       mBlk;
    logic             mErr;
    logic             mAcc;
    logic [31:0]      rdQ;

    fpec_top fpec_top_i (
        .ref_clk         (ref_clk),
        .rstn            (rstn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .flashFault      (flashFault),
        .flashCtrl       (flashCtrl)
    );

    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------------
    // Expectation functions and reporting
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // The run and the erase bits take only with their setup bit already set.
    function automatic logic [7:0] next_mode(logic [7:0] cur, logic [7:0] wd);
        logic [7:0] r;
        r = wd[6] ? (wd & 8'h7C) : 8'h00;
        r[1] = wd[6] & wd[5] & wd[1] & cur[5] & ~mErr;
        r[0] = wd[6] & wd[4] & wd[0] & cur[4] & ~mErr;
        return r;
    endfunction

    function automatic logic [31:0] exp_read(logic [3:0] a);
        case (a)
            `FPEC_OFS_MODE_CTL:   return mAcc ? {25'h0, mMode[6:0]} : 32'h0;
            `FPEC_OFS_ERR_STATUS: return mAcc ? {24'h0, mErr, 7'h00} : 32'h0;
            `FPEC_OFS_ERASE_BLK:  return mAcc ? {25'h0, mBlk[6:0]} : 32'h0;
            `FPEC_OFS_ACCESS:     return {24'h0, mAcc, 7'h00};
            default:              return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] exp_ctrl();
        return {18'h0, mMode[5], mMode[4], mMode[3], mMode[2], mMode[1], mMode[0],
                mErr, mBlk[6:0]};
    endfunction

    function automatic void model_write(logic [3:0] a, logic [31:0] d, logic [3:0] be);
        if (be[0]) begin
            if (a == `FPEC_OFS_ACCESS) mAcc = d[7];
            if (mAcc && a == `FPEC_OFS_MODE_CTL) begin
                mMode = next_mode(mMode, d[7:0]);
                if (!mMode[6]) mBlk = 8'h00;
            end
            if (mAcc && a == `FPEC_OFS_ERASE_BLK && mMode[6])
                mBlk = ($countones(d[6:0]) > 1) ? 8'h00 : {1'b0, d[6:0]};
        end
    endfunction

    function automatic void model_reset();
        mMode = 8'h00;
        mBlk  = 8'h00;
        mErr  = 1'b0;
        mAcc  = 1'b0;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Bus master: waitrequest and read data are taken at the rising edge.
    // ------------------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        // Only the watchdog ends a wait that never gets its answer.
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic check_state();
        @(negedge ref_clk);
        check(32'(flashCtrl), exp_ctrl());
    endtask

    task automatic rd_check(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hF, rdQ);
        check(rdQ, exp_read(a));
    endtask

    // Software never writes the read-only status register.
    task automatic wrc(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be, rdQ);
        model_write(a, d, be);
        rd_check(a);
        check_state();
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        model_reset();
    endtask

    // ------------------------------------------------------------------------
    // Directed sequence: run bits are also written together with their setup bits, where they must not take.
    // ------------------------------------------------------------------------
    localparam logic [11:0] SEQ [0:18] = '{
        12'hC00, 12'h03F, 12'h801, 12'hC80, 12'h03F, 12'h801, 12'h040, 12'h062,
        12'h062, 12'h060, 12'h050, 12'h051, 12'h04C, 12'h040, 12'h804, 12'h805,
        12'h840, 12'h000, 12'h8FF
    };

    initial begin
        ref_clk = 1'b0; rstn = 1'b0; avs_address = 4'h0; avs_read = 1'b0;
        avs_write = 1'b0; avs_writedata = 32'h0; avs_byteenable = 4'h0;
        flashFault = 1'b0; err_total = 0; checked = 0; rng = 32'hF25CACAA;
        model_reset();
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 16; i += 4) rd_check(4'(i));
        wrc(`FPEC_OFS_ACCESS, 32'h80, 4'hE);
        foreach (SEQ[i]) wrc(SEQ[i][11:8], {24'h0, SEQ[i][7:0]}, 4'hF);
        for (int i = 0; i < 150; i++) begin
            logic [31:0] r;
            r = xs();
            // A draw that lands on the status register turns into a read.
            if (r[3:2] == 2'h0 || {r[9:8], 2'b00} == `FPEC_OFS_ERR_STATUS)
                rd_check(4'(r[11:8]));
            else
                wrc(4'({r[9:8], 2'b00}), xs(), r[7:4] | 4'(r[12]));
        end
        wrc(`FPEC_OFS_ACCESS, 32'h80, 4'hF);
        wrc(`FPEC_OFS_MODE_CTL, 32'h60, 4'hF);
        // A fault with neither run bit set must not raise the flag.
        @(posedge ref_clk) flashFault <= 1'b1;
        repeat (4) @(posedge ref_clk);
        flashFault <= 1'b0;
        check_state();
        wrc(`FPEC_OFS_MODE_CTL, 32'h62, 4'hF);
        @(posedge ref_clk) flashFault <= 1'b1;
        @(posedge ref_clk) flashFault <= 1'b0;
        mErr = 1'b1;
        mMode[1:0] = 2'b00;
        repeat (2) @(posedge ref_clk);
        check_state();
        rd_check(`FPEC_OFS_ERR_STATUS);
        wrc(`FPEC_OFS_MODE_CTL, 32'h50, 4'hF);
        wrc(`FPEC_OFS_MODE_CTL, 32'h51, 4'hF);
        wrc(`FPEC_OFS_MODE_CTL, 32'h62, 4'hF);
        do_reset();
        check_state();
        wrc(`FPEC_OFS_ACCESS, 32'h80, 4'hF);
        rd_check(`FPEC_OFS_ERR_STATUS);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
endmodule // tb
